// [modbus_slave.v]
// command interpreter for read holding, write coil and write holding register
`include "modbus_defines.vh"
module modbus_slave #(
  parameter [7:0] SLAVE_ADDR = 8'h01
) (
  // clock and reset
  input  wire        mclk,
  input  wire        arst_n,
  // received frame bytes, already framed by the line receiver
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  input  wire        rx_end,
  // transmit byte stream
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  input  wire        tx_ready,
  output reg         tx_done,
  // drive-side status inputs
  input  wire [15:0] trip_cause,
  input  wire [15:0] trip_state,
  // drive-side controls
  output reg         run_cmd,
  output reg  [15:0] base_freq,
  output reg  [15:0] cmd_source
);
  localparam [3:0] ST_RX = 4'h1, ST_EXEC = 4'h2, ST_TX = 4'h4, ST_CRC = 4'h8;
  reg  [3:0]  state_reg;
  reg  [7:0]  buf_reg [0:7];
  reg  [3:0]  cnt_reg;
  reg  [15:0] crc_reg;
  reg  [7:0]  tx_len_reg;
  reg  [7:0]  tx_idx_reg;
  reg  [7:0]  func_reg;
  reg  [7:0]  exc_reg;
  reg         crc_byte_reg;
  wire [15:0] crc_next;
  reg  [7:0]  tx_byte;
  wire [15:0] f_addr  = {buf_reg[2], buf_reg[3]};
  wire [15:0] f_value = {buf_reg[4], buf_reg[5]};
  wire [15:0] reg_num = f_addr + 16'h0001;
  wire [15:0] rd_count = f_value;
  wire [15:0] rx_crc  = {buf_reg[7], buf_reg[6]};
  wire        is_bcast = (buf_reg[0] == `BROADCAST_ADDR);
  wire        for_us   = is_bcast || (buf_reg[0] == SLAVE_ADDR);
  integer k;

  crc16_byte u_crc (
    .crc_in  (crc_reg),
    .data_in ((state_reg == ST_RX) ? rx_data : tx_byte),
    .crc_out (crc_next)
  );

  // register lookup for the read reply; unknown numbers read as zero
  function [15:0] read_reg;
    input [15:0] num;
    begin
      case (num)
        `REG_TRIP_CAUSE: read_reg = trip_cause;
        `REG_TRIP_STATE: read_reg = trip_state;
        `REG_BASE_FREQ:  read_reg = base_freq;
        `REG_CMD_SOURCE: read_reg = cmd_source;
        default:         read_reg = 16'h0000;
      endcase
    end
  endfunction

  // reply bytes 3 and 4 carry the first word, so the word index counts from byte 3
  wire [7:0]  rd_off   = tx_idx_reg - 8'h03;
  wire [15:0] rd_num   = reg_num + {9'h000, rd_off[7:1]};
  wire [15:0] rd_word  = read_reg(rd_num);

  always @* begin
    if (exc_reg != 8'h00) begin
      case (tx_idx_reg)
        8'h00:   tx_byte = buf_reg[0];
        8'h01:   tx_byte = func_reg | `FC_EXCEPTION_BIT;
        default: tx_byte = exc_reg;
      endcase
    end else if (func_reg == `FC_READ_HOLD) begin
      case (tx_idx_reg)
        8'h00:   tx_byte = buf_reg[0];
        8'h01:   tx_byte = func_reg;
        8'h02:   tx_byte = {rd_count[6:0], 1'b0};
        default: tx_byte = tx_idx_reg[0] ? rd_word[15:8] : rd_word[7:0];
      endcase
    end else begin
      tx_byte = buf_reg[tx_idx_reg[2:0]];
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= ST_RX;
      cnt_reg      <= 4'h0;
      crc_reg      <= `CRC_INIT;
      tx_len_reg   <= 8'h00;
      tx_idx_reg   <= 8'h00;
      func_reg     <= 8'h00;
      exc_reg      <= 8'h00;
      crc_byte_reg <= 1'b0;
      tx_data      <= 8'h00;
      tx_valid     <= 1'b0;
      tx_done      <= 1'b0;
      run_cmd      <= 1'b0;
      base_freq    <= `BASE_FREQ_RESET;
      cmd_source   <= `CMD_SOURCE_RESET;
      for (k = 0; k < 8; k = k + 1) begin
        buf_reg[k] <= 8'h00;
      end
    end else begin
      tx_done <= 1'b0;
      case (state_reg)
        ST_RX: begin
          if (rx_valid) begin
            if (cnt_reg < 4'h8) begin
              buf_reg[cnt_reg[2:0]] <= rx_data;
            end
            // keep counting past eight so an overlong frame is rejected
            if (cnt_reg != 4'hf) begin
              cnt_reg <= cnt_reg + 4'h1;
            end
            // crc runs over the address through the data only
            if (cnt_reg < 4'h6) begin
              crc_reg <= crc_next;
            end
          end
          if (rx_end) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // bad length, crc or address: drop silently, like a line error
          state_reg <= ST_RX;
          func_reg  <= buf_reg[1];
          exc_reg   <= 8'h00;
          tx_idx_reg <= 8'h00;
          if (cnt_reg == 4'h8 && rx_crc == crc_reg && for_us) begin
            case (buf_reg[1])
              `FC_READ_HOLD: begin
                if (!is_bcast) begin
                  state_reg <= ST_TX;
                  if (rd_count == 16'h0000 || rd_count > `MAX_READ_COUNT) begin
                    exc_reg    <= `EXC_ILLEGAL_DATA;
                    tx_len_reg <= 8'h03;
                  end else begin
                    tx_len_reg <= 8'h03 + {rd_count[6:0], 1'b0};
                  end
                end
              end
              `FC_WRITE_COIL: begin
                state_reg  <= is_bcast ? ST_RX : ST_TX;
                tx_len_reg <= 8'h06;
                if (reg_num != `COIL_RUN_NUMBER) begin
                  exc_reg    <= `EXC_ILLEGAL_ADDR;
                  tx_len_reg <= 8'h03;
                end else if (f_value != `COIL_ON_VALUE && f_value != `COIL_OFF_VALUE) begin
                  exc_reg    <= `EXC_ILLEGAL_DATA;
                  tx_len_reg <= 8'h03;
                end else if (f_value == `COIL_ON_VALUE && cmd_source != `CMD_SRC_LINK) begin
                  exc_reg    <= `EXC_ILLEGAL_DATA;
                  tx_len_reg <= 8'h03;
                end else begin
                  run_cmd <= (f_value == `COIL_ON_VALUE);
                end
              end
              `FC_WRITE_HOLD: begin
                state_reg  <= is_bcast ? ST_RX : ST_TX;
                tx_len_reg <= 8'h06;
                if (reg_num == `REG_BASE_FREQ) begin
                  base_freq <= f_value;
                end else if (reg_num == `REG_CMD_SOURCE) begin
                  cmd_source <= f_value;
                end else begin
                  exc_reg    <= `EXC_ILLEGAL_ADDR;
                  tx_len_reg <= 8'h03;
                end
              end
              default: begin
                state_reg  <= is_bcast ? ST_RX : ST_TX;
                exc_reg    <= `EXC_ILLEGAL_FUNC;
                tx_len_reg <= 8'h03;
              end
            endcase
          end
          cnt_reg <= 4'h0;
          crc_reg <= `CRC_INIT;
        end
        ST_TX: begin
          if (!tx_valid || tx_ready) begin
            if (tx_idx_reg == tx_len_reg) begin
              // crc goes out low byte first on the wire
              tx_data      <= crc_reg[7:0];
              tx_valid     <= 1'b1;
              crc_byte_reg <= 1'b0;
              state_reg    <= ST_CRC;
            end else begin
              tx_data    <= tx_byte;
              tx_valid   <= 1'b1;
              crc_reg    <= crc_next;
              tx_idx_reg <= tx_idx_reg + 8'h01;
            end
          end
        end
        ST_CRC: begin
          if (tx_ready) begin
            if (!crc_byte_reg) begin
              tx_data      <= crc_reg[15:8];
              crc_byte_reg <= 1'b1;
            end else begin
              tx_valid  <= 1'b0;
              tx_done   <= 1'b1;
              crc_reg   <= `CRC_INIT;
              state_reg <= ST_RX;
            end
          end
        end
        default: begin
          state_reg <= ST_RX;
        end
      endcase
    end
  end
endmodule // modbus_slave

// [modbus_defines.vh]
// constants for the register and coil command interpreter
`ifndef MODBUS_DEFINES_VH
`define MODBUS_DEFINES_VH
`define FC_READ_HOLD      8'h03
`define FC_WRITE_COIL     8'h05
`define FC_WRITE_HOLD     8'h06
`define FC_EXCEPTION_BIT  8'h80
`define EXC_ILLEGAL_FUNC  8'h01
`define EXC_ILLEGAL_ADDR  8'h02
`define EXC_ILLEGAL_DATA  8'h03
`define BROADCAST_ADDR    8'h00
`define COIL_ON_VALUE     16'hff00
`define COIL_OFF_VALUE    16'h0000
`define COIL_RUN_NUMBER   16'h0001
`define CMD_SRC_LINK      16'h0003
`define REG_TRIP_CAUSE    16'h0012
`define REG_TRIP_STATE    16'h0013
`define REG_BASE_FREQ     16'h1203
`define REG_CMD_SOURCE    16'h1202
`define BASE_FREQ_RESET   16'h003c
`define CMD_SOURCE_RESET  16'h0001
`define MAX_READ_COUNT    16'h007d
`define CRC_INIT          16'hffff
`define CRC_POLY          16'ha001
`endif

// [crc16_byte.v]
// one byte step of the frame check sequence (reflected polynomial)
`include "modbus_defines.vh"
module crc16_byte (
  // input state and byte
  input  wire [15:0] crc_in,
  input  wire [7:0]  data_in,
  // updated state
  output reg  [15:0] crc_out
);
  integer i;
  always @* begin
    crc_out = crc_in ^ {8'h00, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[0]) begin
        crc_out = (crc_out >> 1) ^ `CRC_POLY;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end
endmodule // crc16_byte

// [modbus_slave_asserts.sv]
// port assertions for the command interpreter
module modbus_slave_asserts #(parameter [7:0] SLAVE_ADDR = 8'h01) (
  // all ports of the interpreter, watched only
  input wire logic        mclk, arst_n, rx_valid, rx_end, tx_valid, tx_ready, tx_done, run_cmd,
  input wire logic [7:0]  rx_data, tx_data,
  input wire logic [15:0] trip_cause, trip_state, base_freq, cmd_source
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved before taken");
  reply_lat_a: assert property ($rose(tx_valid) |-> $past(rx_end, 3))
    else $error("reply start off its slot");
  reply_addr_a: assert property ($rose(tx_valid) |-> tx_data == SLAVE_ADDR)
    else $error("reply opens with wrong address");
  done_pulse_a: assert property (tx_done |-> $past(tx_valid && tx_ready) ##1 !tx_done)
    else $error("done not a pulse after last byte");
  drop_done_a: assert property ($fell(tx_valid) |-> tx_done)
    else $error("reply stopped without done");
  ctl_lat_a: assert property ($changed({run_cmd, base_freq, cmd_source}) |-> $past(rx_end, 2))
    else $error("control changed outside a command");
  run_src_a: assert property ($rose(run_cmd) |-> cmd_source == 16'h0003)
    else $error("run set with wrong source");
  done_gap_a: assert property (tx_done |-> !tx_valid [*3])
    else $error("reply restarted after done");
  cover property (tx_done);
  cover property ($rose(run_cmd));
  cover property ($changed(base_freq) && !tx_valid);
endmodule // modbus_slave_asserts

// [modbus_master_model.sv]
// master side model: sends framed queries and collects the reply bytes
module modbus_master_model (
  // reply stream from the interpreter
  input  wire logic       mclk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  // query stream and sink ready
  output logic [7:0]      rx_data,
  output logic            rx_valid, rx_end, tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] reply[$];
  bit         slow = 0;
  initial begin
    rx_data = 8'h5a;
    rx_valid = 0;
    rx_end = 0;
  end
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // fields high byte first; check word goes low byte first, as the line carries it
  task automatic send(input logic [47:0] q, input logic [15:0] flip);
    logic [15:0] c;
    logic [7:0]  b[8];
    c = 16'hffff;
    for (int i = 0; i < 6; i++) begin
      b[i] = q[47-8*i -: 8];
      c = crc_step(c, b[i]);
    end
    c = c ^ flip;
    b[6] = c[7:0];
    b[7] = c[15:8];
    foreach (b[i]) begin
      @(negedge mclk);
      rx_data = b[i];
      rx_valid = 1;
    end
    // idle data is not left showing the last byte
    @(negedge mclk);
    rx_valid = 0;
    rx_data = ~rx_data;
    rx_end = 1;
    @(negedge mclk);
    rx_end = 0;
  endtask
  always @(posedge mclk) if (tx_valid && tx_ready) reply.push_back(tx_data);
  always @(negedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;
endmodule // modbus_master_model

// [modbus_register_coil_access_tb_top.sv]
// bench: table of queries through the master model, then fault and reset cases
module modbus_register_coil_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [47:0] q; logic [55:0] r; int n; logic [15:0] bf; logic run;} row_t;
  logic        mclk = 0, arst_n = 0, rx_valid, rx_end, tx_valid, tx_ready, tx_done, run_cmd;
  logic [7:0]  rx_data, tx_data;
  logic [15:0] trip_cause = 16'h0007, trip_state = 16'h0002, base_freq, cmd_source;
  int          miscompares = 0, check_count = 0, cyc = 0;
  row_t rows[15] = '{
    '{48'h010612020032, 56'h01061202003200, 6, 16'h0032, 0},
    '{48'h010300110002, 56'h01030400070002, 7, 16'h0032, 0},
    '{48'h01050000ff00, 56'h01850300000000, 3, 16'h0032, 0},
    '{48'h010612010003, 56'h01061201000300, 6, 16'h0032, 0},
    '{48'h01050000ff00, 56'h01050000ff0000, 6, 16'h0032, 1},
    '{48'h010500001234, 56'h01850300000000, 3, 16'h0032, 1},
    '{48'h000500000000, 56'h0, 0, 16'h0032, 0},
    '{48'h000612020028, 56'h0, 0, 16'h0028, 0},
    '{48'h000300110001, 56'h0, 0, 16'h0028, 0},
    '{48'h020612020011, 56'h0, 0, 16'h0028, 0},
    '{48'h010400000001, 56'h01840100000000, 3, 16'h0028, 0},
    '{48'h010300110000, 56'h01830300000000, 3, 16'h0028, 0},
    '{48'h010600050007, 56'h01860200000000, 3, 16'h0028, 0},
    '{48'h010500050000, 56'h01850200000000, 3, 16'h0028, 0},
    '{48'h010312020001, 56'h01030200280000, 5, 16'h0028, 0}};
  modbus_slave modbus_slave_i (.mclk(mclk), .arst_n(arst_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_end(rx_end), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_done(tx_done),
    .trip_cause(trip_cause), .trip_state(trip_state), .run_cmd(run_cmd), .base_freq(base_freq),
    .cmd_source(cmd_source));
  modbus_master_model modbus_master_model_i (.mclk(mclk), .tx_data(tx_data), .tx_valid(tx_valid),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .tx_ready(tx_ready));
  always #5 mclk = ~mclk;
  task automatic chk(string name, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a silent slave only gets a fixed quiet window
  task automatic query(logic [47:0] q, logic [15:0] flip, logic [55:0] r, int n);
    logic [15:0] c;
    c = 16'hffff;
    modbus_master_model_i.reply.delete();
    modbus_master_model_i.send(q, flip);
    if (n > 0) for (int k = 0; k < 600 && tx_done !== 1'b1; k++) @(negedge mclk);
    else repeat (20) @(negedge mclk);
    for (int i = 0; i < n; i++) c = modbus_master_model_i.crc_step(c, r[55-8*i -: 8]);
    chk("reply length", 16'(n ? n + 2 : 0), 16'(modbus_master_model_i.reply.size()));
    for (int i = 0; i < n; i++) chk("reply byte", r[55-8*i -: 8], modbus_master_model_i.reply[i]);
    if (n > 0) chk("check word", c, {modbus_master_model_i.reply[n+1], modbus_master_model_i.reply[n]});
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    arst_n = 1;
    chk("freq at reset", 16'h003c, base_freq);
    chk("source at reset", 16'h0001, cmd_source);
    foreach (rows[i]) begin
      modbus_master_model_i.slow = i[0];
      query(rows[i].q, 16'h0000, rows[i].r, rows[i].n);
      chk("base freq", rows[i].bf, base_freq);
      chk("run", 16'(rows[i].run), 16'(run_cmd));
      $display("row %0d done", i);
    end
    query(48'h010612020064, 16'h0001, 56'h0, 0); // corrupted check word is dropped
    chk("freq kept", 16'h0028, base_freq);
    $display("bad check word test done");
    query(48'h01050000ff00, 16'h0000, 56'h01050000ff0000, 6);
    chk("run before reset", 16'h0001, 16'(run_cmd));
    arst_n = 0;
    @(negedge mclk);
    arst_n = 1;
    chk("run after reset", 16'h0000, 16'(run_cmd));
    chk("freq after reset", 16'h003c, base_freq);
    chk("source after reset", 16'h0001, cmd_source);
    $display("second reset test done");
    final_report();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
endmodule // modbus_register_coil_access_tb_top
bind modbus_slave modbus_slave_asserts #(.SLAVE_ADDR(SLAVE_ADDR)) modbus_slave_asserts_i (.*);
